// ---- cbc_pkg.sv ----
// Shared constants, types and decode functions of the control-block chain logic
package cbc_pkg;
    // APB register offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CCB_ADDR = 8'h08;
    localparam logic [7:0] REG_CIB_ADDR = 8'h0c;
    localparam logic [7:0] REG_PARAMETER_BLOCK_PTR = 8'h10;
    localparam logic [7:0] REG_EXEC = 8'h14;
    localparam logic [7:0] REG_OPSTAT = 8'h18;
    // Program commands in the low two bits of a command write
    localparam logic [1:0] CMD_CLEAR = 2'h0;
    localparam logic [1:0] CMD_START = 2'h1;
    localparam logic [1:0] CMD_RESET = 2'h2;
    // Wake-up extension byte bits and valid values
    localparam int MODE_LINEAR_BIT = 1;
    localparam int MODE_EXT_BIT = 2;
    localparam logic [7:0] MODE_SEG = 8'h01;
    localparam logic [7:0] MODE_LIN = 8'h03;
    localparam logic [7:0] MODE_SEG_EXT = 8'h05;
    localparam logic [7:0] MODE_LIN_EXT = 8'h07;
    // Memory byte values
    localparam logic [7:0] CCB_TAG = 8'h01;
    localparam logic [7:0] BUSY_CLEAR = 8'h00;
    localparam logic [7:0] SEM_FREE = 8'h00;
    localparam logic [7:0] SEM_POSTED = 8'hff;
    // Byte offsets within the blocks
    localparam logic [3:0] WUB_FIRST = 4'h0;
    localparam logic [3:0] WUB_LAST = 4'h5;
    localparam logic [3:0] CCB_TAG_OFS = 4'h0;
    localparam logic [3:0] CCB_BUSY_OFS = 4'h1;
    localparam logic [3:0] CCB_LAST = 4'h5;
    localparam logic [3:0] CIB_FIRST = 4'h4;
    localparam logic [3:0] CIB_LAST = 4'hb;
    localparam logic [3:0] CIB_STAT_OFS = 4'h1;
    localparam logic [3:0] CIB_SEM_OFS = 4'h3;
    localparam logic [3:0] PARAMETER_BLOCK_FIRST = 4'h8;
    localparam logic [3:0] PARAMETER_BLOCK_LAST = 4'hb;
    localparam logic [3:0] PARAMETER_BLOCK_CNT_FIRST = 4'h4;
    localparam logic [3:0] PARAMETER_BLOCK_CNT_LAST = 4'h7;
    localparam logic [23:0] CIB_PTR_BIAS = 24'h000004;
    localparam int WUB_SHIFT = 4;
    // Device selector values
    localparam logic [15:0] DEV_WIN = 16'h0000;
    localparam logic [15:0] DEV_FLOPPY = 16'h0001;
    localparam logic [15:0] DEV_TAPE_C = 16'h0004;
    localparam logic [15:0] DEV_TAPE_N = 16'h0010;
    // Function codes
    localparam logic [7:0] FN_XFER_STATUS = 8'h01;
    localparam logic [7:0] FN_FORMAT = 8'h02;
    localparam logic [7:0] FN_READ = 8'h04;
    localparam logic [7:0] FN_WRITE = 8'h06;
    localparam logic [7:0] FN_SEEK = 8'h08;
    localparam logic [7:0] FN_DIAG = 8'h0f;
    // Operation status codes, bits 3 to 0
    localparam logic [3:0] ST_WIN_IMM = 4'h1;
    localparam logic [3:0] ST_WIN_SEEK = 4'h2;
    localparam logic [3:0] ST_MEDIA = 4'h4;
    localparam logic [3:0] ST_FLP_IMM = 4'h9;
    localparam logic [3:0] ST_FLP_SEEK = 4'ha;
    localparam logic [3:0] ST_FLP_MEDIA = 4'hc;
    localparam logic [3:0] ST_TAPE_MEDIA = 4'he;
    localparam logic [3:0] ST_TAPE_LONG = 4'hf;

    typedef enum logic [2:0] {
        KIND_WIN, KIND_FLOPPY, KIND_TAPE_C, KIND_TAPE_N, KIND_BAD
    } devkind_t;
    typedef enum logic [2:0] {
        FC_XFER, FC_FORMAT, FC_READ, FC_WRITE, FC_SEEK, FC_DIAG, FC_OTHER
    } fnclass_t;
    typedef enum logic [1:0] {EV_IMM, EV_SEEK, EV_MEDIA, EV_LONG} event_t;
    typedef enum logic [11:0] {
        S_IDLE = 12'h001, S_WUB = 12'h002, S_CCB = 12'h004, S_CIB = 12'h008,
        S_BUSY1 = 12'h010, S_PARAMETER_BLOCK = 12'h020, S_EXEC = 12'h040, S_COUNT = 12'h080,
        S_SEM = 12'h100, S_POST = 12'h200, S_SEMSET = 12'h400, S_HALT = 12'h800
    } state_t;

    function automatic devkind_t devKind(input logic [15:0] sel);
        if (sel == DEV_WIN) return KIND_WIN;
        else if (sel == DEV_FLOPPY) return KIND_FLOPPY;
        else if (sel == DEV_TAPE_C) return KIND_TAPE_C;
        else if (sel == DEV_TAPE_N) return KIND_TAPE_N;
        else return KIND_BAD;
    endfunction

    function automatic fnclass_t fnClass(input logic [7:0] code);
        if (code == FN_XFER_STATUS) return FC_XFER;
        else if (code == FN_FORMAT) return FC_FORMAT;
        else if (code == FN_READ) return FC_READ;
        else if (code == FN_WRITE) return FC_WRITE;
        else if (code == FN_SEEK) return FC_SEEK;
        else if (code == FN_DIAG) return FC_DIAG;
        else return FC_OTHER;
    endfunction
endpackage

// ---- addr_former.sv ----
// Turns a four-byte segment:offset pointer into a 24-bit host bus address
`timescale 1ns/10ps
module addr_former
    import cbc_pkg::*;
(
    input wire logic [31:0] ptr,
    input wire logic linear,
    output logic [23:0] addr
);
    logic [15:0] offset;
    logic [15:0] segment;

    always_comb begin
        offset = ptr[15:0];
        segment = ptr[31:16];
        if (linear) begin
            // Top byte of the segment is ignored in linear mode
            addr = {segment[7:0], offset};
        end else begin
            addr = {4'h0, segment, 4'h0} + {8'h00, offset};
        end
    end
endmodule

// ---- ptr_assembler.sv ----
// Gathers fetched bytes, least significant first, into a 32-bit word
`timescale 1ns/10ps
module ptr_assembler
    import cbc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic load,
    input wire logic [7:0] byteIn,
    output logic [31:0] word,
    output logic [31:0] wordNow
);
    typedef struct packed {
        logic [31:0] word;
    } asm_t;

    asm_t s_r;
    asm_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (load) begin
            s_nxt.word = {byteIn, s_r.word[31:8]};
        end
    end

    // Lets the caller use the word in the same cycle as its last byte
    assign wordNow = s_nxt.word;
    assign word = s_r.word;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ---- control_block_chain_fetch.sv ----
// Control-block chain walker with APB command and status registers
`timescale 1ns/10ps
// Functional notes
// - First start reads the wake-up block at the jumper address and keeps it.
// - Channel block pointer comes from wake-up bytes 2 to 5.
// - Wake-up byte 0 selects segmented or linear addressing and extended features.
// - Wake-up block is read only on the first start after reset.
// - Extended features cannot be enabled again until a full reset.
// - Channel byte 0 other than 01h halts with no status and lights the error.
// - Host sets busy flag to FFh; controller clears it on first start.
// - Invocation pointer from channel bytes 2 to 5 addresses its byte 4.
// - The last ten channel block bytes are never read.
// - Channel and invocation addresses are stored and reused until reset.
// - Status is posted only while the semaphore is 00h, then set to FFh.
// - Parameter block pointer comes from invocation bytes 8 to 11.
// - Operation status byte takes the latest transfer status result.
// - Status bits 3 to 0 encode drive class and event.
// - Only the actual transfer count is written into the parameter block.
// - Parameter bytes 8 and 9 select the device.
// - Parameter byte 11 is the function code.
// - Command write: low two bits give clear, start or reset.
// - Later starts fetch the parameter block by the stored pointer and run.
// - Reset command aborts everything and posts no status.
module control_block_chain_fetch
    import cbc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] wakeupJumperLow,
    input wire logic [7:0] wakeupJumperHigh,
    output logic memReq,
    output logic memWe,
    output logic [23:0] memAddr,
    output logic [7:0] memWdata,
    input wire logic memAck,
    input wire logic [7:0] memRdata,
    output logic execGo,
    output logic [15:0] execDevice,
    output logic [7:0] execUnit,
    output logic [7:0] execFunction,
    output logic [2:0] execDeviceKind,
    output logic [2:0] execFuncClass,
    input wire logic doneValid,
    input wire logic [1:0] doneEvent,
    input wire logic [31:0] doneCount,
    output logic errorIndicator,
    output logic linearMode,
    output logic extEnabled
);
    typedef struct packed {
        state_t st;
        logic [3:0] idx;
        logic memReq;
        logic memWe;
        logic [23:0] memAddr;
        logic [7:0] memWdata;
        logic [15:0] jSync1;
        logic [15:0] jSync2;
        logic [15:0] jSync3;
        logic [15:0] jStable;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic linear;
        logic ext;
        logic wubDone;
        logic resetHeld;
        logic err;
        logic [23:0] ccbBase;
        logic [23:0] cibBase;
        logic [31:0] iopbPtr;
        logic [23:0] iopbBase;
        logic execGo;
        logic [15:0] dev;
        logic [7:0] unit;
        logic [7:0] func;
        devkind_t kind;
        fnclass_t fclass;
        logic [31:0] count;
        logic [7:0] opStatus;
    } state_s_t;

    state_s_t s_r;
    state_s_t s_nxt;

    logic memDone;
    logic [31:0] word;
    logic [31:0] wordNow;
    logic [23:0] formed;

    // Status code from the drive class and the reported event
    function automatic logic [3:0] encStatus(input devkind_t k, input logic [1:0] ev);
        logic [3:0] code;
        code = 4'h0;
        case (k)
            KIND_WIN: begin
                if (ev == EV_IMM) code = ST_WIN_IMM;
                else if (ev == EV_SEEK) code = ST_WIN_SEEK;
                else if (ev == EV_MEDIA) code = ST_MEDIA;
            end
            KIND_FLOPPY: begin
                if (ev == EV_IMM) code = ST_FLP_IMM;
                else if (ev == EV_SEEK) code = ST_FLP_SEEK;
                else if (ev == EV_MEDIA) code = ST_FLP_MEDIA;
            end
            KIND_TAPE_C: begin
                if (ev == EV_IMM) code = ST_FLP_IMM;
                else if (ev == EV_MEDIA) code = ST_TAPE_MEDIA;
                else if (ev == EV_LONG) code = ST_TAPE_LONG;
            end
            KIND_TAPE_N: begin
                if (ev == EV_IMM) code = ST_FLP_IMM;
                else if (ev == EV_MEDIA) code = ST_MEDIA;
                else if (ev == EV_LONG) code = ST_TAPE_LONG;
            end
            default: code = 4'h0;
        endcase
        return code;
    endfunction

    assign memDone = s_r.memReq & memAck;

    ptr_assembler u_asm (
        .mclk(mclk),
        .rst(rst),
        .load(memDone & ~s_r.memWe),
        .byteIn(memRdata),
        .word(word),
        .wordNow(wordNow)
    );

    addr_former u_form (
        .ptr(wordNow),
        .linear(s_r.linear),
        .addr(formed)
    );

    always_comb begin
        logic apbAccess;
        logic issue;
        logic wr;
        logic [23:0] base;
        logic [7:0] wdata;
        logic [31:0] rdata;
        logic mapped;
        apbAccess = psel & penable;
        issue = 1'b0;
        wr = 1'b0;
        base = 24'h000000;
        wdata = 8'h00;
        rdata = 32'h00000000;
        mapped = 1'b1;
        s_nxt = s_r;
        s_nxt.execGo = 1'b0;

        // Jumper straps: a change counts once stages two and three agree
        s_nxt.jSync1 = {wakeupJumperHigh, wakeupJumperLow};
        s_nxt.jSync2 = s_r.jSync1;
        s_nxt.jSync3 = s_r.jSync2;
        if (s_r.jSync2 == s_r.jSync3) begin
            s_nxt.jStable = s_r.jSync3;
        end

        // APB read side; answer one cycle into the access phase
        if (paddr == REG_CMD) begin
            rdata = 32'h00000000;
        end else if (paddr == REG_STATUS) begin
            rdata = {4'h0, s_r.st, 10'h000, s_r.st != S_IDLE, s_r.err,
                     s_r.resetHeld, s_r.ext, s_r.linear, s_r.wubDone};
        end else if (paddr == REG_CCB_ADDR) begin
            rdata = {8'h00, s_r.ccbBase};
        end else if (paddr == REG_CIB_ADDR) begin
            rdata = {8'h00, s_r.cibBase};
        end else if (paddr == REG_PARAMETER_BLOCK_PTR) begin
            rdata = s_r.iopbPtr;
        end else if (paddr == REG_EXEC) begin
            rdata = {s_r.func, s_r.unit, s_r.dev};
        end else if (paddr == REG_OPSTAT) begin
            rdata = {18'h00000, s_r.fclass, s_r.kind, s_r.opStatus};
        end else begin
            mapped = 1'b0;
        end
        s_nxt.pready = apbAccess & ~s_r.pready;
        if (apbAccess & ~s_r.pready) begin
            s_nxt.prdata = pwrite ? 32'h00000000 : rdata;
            s_nxt.pslverr = ~mapped;
        end

        case (s_r.st)
            S_IDLE: begin
            end
            S_WUB: begin
                issue = ~s_r.memReq;
                base = {4'h0, s_r.jStable, 4'h0} >> (4 - WUB_SHIFT);
                if (memDone) begin
                    // Only a session without a captured wake-up block may set modes
                    if (s_r.idx == WUB_FIRST && !s_r.wubDone) begin
                        s_nxt.linear = memRdata[MODE_LINEAR_BIT];
                        s_nxt.ext = memRdata[MODE_EXT_BIT];
                    end
                    if (s_r.idx == WUB_LAST) begin
                        s_nxt.ccbBase = formed;
                        s_nxt.st = S_CCB;
                        s_nxt.idx = CCB_TAG_OFS;
                    end else begin
                        s_nxt.idx = s_r.idx + 4'h1;
                    end
                end
            end
            S_CCB: begin
                issue = ~s_r.memReq;
                base = s_r.ccbBase;
                if (memDone) begin
                    if (s_r.idx == CCB_TAG_OFS && memRdata != CCB_TAG) begin
                        s_nxt.st = S_HALT;
                        s_nxt.err = 1'b1;
                    end else if (s_r.idx == CCB_LAST) begin
                        // Fetch stops here; the tail of the block is never touched
                        s_nxt.cibBase = formed;
                        s_nxt.st = S_CIB;
                        s_nxt.idx = CIB_FIRST;
                    end else begin
                        s_nxt.idx = s_r.idx + 4'h1;
                    end
                end
            end
            S_CIB: begin
                issue = ~s_r.memReq;
                // Stored pointer names byte 4, so byte n sits at base - 4 + n
                base = s_r.cibBase - CIB_PTR_BIAS;
                if (memDone) begin
                    if (s_r.idx == CIB_LAST) begin
                        s_nxt.iopbPtr = wordNow;
                        s_nxt.iopbBase = formed;
                        s_nxt.st = S_BUSY1;
                        s_nxt.idx = CCB_BUSY_OFS;
                    end else begin
                        s_nxt.idx = s_r.idx + 4'h1;
                    end
                end
            end
            S_BUSY1: begin
                issue = ~s_r.memReq;
                wr = 1'b1;
                base = s_r.ccbBase;
                wdata = BUSY_CLEAR;
                if (memDone) begin
                    s_nxt.wubDone = 1'b1;
                    s_nxt.st = S_IDLE;
                end
            end
            S_PARAMETER_BLOCK: begin
                issue = ~s_r.memReq;
                base = s_r.iopbBase;
                if (memDone) begin
                    if (s_r.idx == PARAMETER_BLOCK_LAST) begin
                        s_nxt.dev = wordNow[15:0];
                        s_nxt.unit = wordNow[23:16];
                        s_nxt.func = wordNow[31:24];
                        s_nxt.kind = devKind(wordNow[15:0]);
                        s_nxt.fclass = fnClass(wordNow[31:24]);
                        s_nxt.execGo = 1'b1;
                        s_nxt.st = S_EXEC;
                    end else begin
                        s_nxt.idx = s_r.idx + 4'h1;
                    end
                end
            end
            S_EXEC: begin
                if (doneValid) begin
                    s_nxt.count = doneCount;
                    if (s_r.fclass == FC_XFER) begin
                        s_nxt.opStatus = {4'h0, encStatus(s_r.kind, doneEvent)};
                    end
                    s_nxt.st = S_COUNT;
                    s_nxt.idx = PARAMETER_BLOCK_CNT_FIRST;
                end
            end
            S_COUNT: begin
                issue = ~s_r.memReq;
                wr = 1'b1;
                base = s_r.iopbBase;
                wdata = s_r.count[7:0];
                if (memDone) begin
                    s_nxt.count = {8'h00, s_r.count[31:8]};
                    if (s_r.idx == PARAMETER_BLOCK_CNT_LAST) begin
                        s_nxt.st = S_SEM;
                        s_nxt.idx = CIB_SEM_OFS;
                    end else begin
                        s_nxt.idx = s_r.idx + 4'h1;
                    end
                end
            end
            S_SEM: begin
                // Polls until the host frees the semaphore; only reset breaks the wait
                issue = ~s_r.memReq;
                base = s_r.cibBase - CIB_PTR_BIAS;
                if (memDone && memRdata == SEM_FREE) begin
                    s_nxt.st = S_POST;
                    s_nxt.idx = CIB_STAT_OFS;
                end
            end
            S_POST: begin
                issue = ~s_r.memReq;
                wr = 1'b1;
                base = s_r.cibBase - CIB_PTR_BIAS;
                wdata = s_r.opStatus;
                if (memDone) begin
                    s_nxt.st = S_SEMSET;
                    s_nxt.idx = CIB_SEM_OFS;
                end
            end
            S_SEMSET: begin
                issue = ~s_r.memReq;
                wr = 1'b1;
                base = s_r.cibBase - CIB_PTR_BIAS;
                wdata = SEM_POSTED;
                if (memDone) begin
                    s_nxt.st = S_IDLE;
                end
            end
            S_HALT: begin
            end
            default: begin
                s_nxt.st = S_IDLE;
            end
        endcase

        if (memDone) begin
            s_nxt.memReq = 1'b0;
        end
        if (issue) begin
            s_nxt.memReq = 1'b1;
            s_nxt.memWe = wr;
            s_nxt.memAddr = base + {20'h00000, s_r.idx};
            s_nxt.memWdata = wdata;
        end

        // Command write takes effect on the completing APB edge
        if (apbAccess && s_r.pready && pwrite && paddr == REG_CMD) begin
            case (pwdata[1:0])
                CMD_CLEAR: begin
                    s_nxt.resetHeld = 1'b0;
                end
                CMD_START: begin
                    if (s_r.st == S_IDLE && !s_r.resetHeld) begin
                        if (!s_r.wubDone) begin
                            s_nxt.st = S_WUB;
                            s_nxt.idx = WUB_FIRST;
                        end else begin
                            s_nxt.st = S_PARAMETER_BLOCK;
                            s_nxt.idx = PARAMETER_BLOCK_FIRST;
                        end
                    end
                end
                CMD_RESET: begin
                    // Drops an open memory cycle at once; nothing is posted
                    s_nxt.st = S_IDLE;
                    s_nxt.memReq = 1'b0;
                    s_nxt.execGo = 1'b0;
                    s_nxt.idx = 4'h0;
                    s_nxt.wubDone = 1'b0;
                    s_nxt.linear = 1'b0;
                    s_nxt.ext = 1'b0;
                    s_nxt.resetHeld = 1'b1;
                    s_nxt.err = 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= S_IDLE;
            s_r.resetHeld <= 1'b1;
            s_r.kind <= KIND_WIN;
            s_r.fclass <= FC_XFER;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign memReq = s_r.memReq;
    assign memWe = s_r.memWe;
    assign memAddr = s_r.memAddr;
    assign memWdata = s_r.memWdata;
    assign execGo = s_r.execGo;
    assign execDevice = s_r.dev;
    assign execUnit = s_r.unit;
    assign execFunction = s_r.func;
    assign execDeviceKind = s_r.kind;
    assign execFuncClass = s_r.fclass;
    assign errorIndicator = s_r.err;
    assign linearMode = s_r.linear;
    assign extEnabled = s_r.ext;
endmodule

// ---- cbc_monitor.sv ----
// Port-level checks of the chain walker
`timescale 1ns/10ps
module cbc_monitor
    import cbc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic memReq,
    input wire logic [23:0] memAddr,
    input wire logic memAck,
    input wire logic execGo,
    input wire logic errorIndicator
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence setupThenAccess;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence oneWait;
        !pready ##1 pready;
    endsequence
    AST_ONE_WAIT: assert property (setupThenAccess |-> oneWait)
        else $error("no answer after one wait");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_UNMAPPED: assert property (pready && paddr > REG_OPSTAT |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    // APB traffic may carry a reset command, which is allowed to cut a request short
    AST_MEM_HOLD: assert property (memReq && !memAck && !psel
        |=> memReq && $stable(memAddr)) else $error("memory request not held");
    AST_MEM_GAP: assert property (memReq && memAck |=> !memReq)
        else $error("memory request not released");
    AST_GO_PULSE: assert property (execGo |=> !execGo)
        else $error("run pulse too long");
    AST_HALT_QUIET: assert property (errorIndicator |-> !memReq)
        else $error("memory access while halted");
    AST_ERR_HOLD: assert property (errorIndicator && !psel |=> errorIndicator)
        else $error("error indicator dropped");
endmodule
bind control_block_chain_fetch cbc_monitor i_mon(.*);

// ---- cbc_host_mem.sv ----
// Host memory model holding the control blocks
`timescale 1ns/10ps
module cbc_host_mem (
    input wire logic mclk,
    input wire logic rst,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [23:0] memAddr,
    input wire logic [7:0] memWdata,
    output logic memAck,
    output logic [7:0] memRdata
);
    logic [7:0] m [256];
    int lag = 0;
    int cnt = 0;
    // Inverse data while idle, so a mistimed sample cannot match
    assign memRdata = memAck ? m[memAddr[7:0]] : ~m[memAddr[7:0]];
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            memAck <= 1'b0;
        end else begin
            memAck <= memReq && !memAck && cnt >= lag;
            cnt <= memReq && !memAck && cnt < lag ? cnt + 1 : 0;
            if (memReq && !memAck && cnt >= lag && memWe) m[memAddr[7:0]] <= memWdata;
        end
    end
endmodule

// ---- tb_control_block_chain_fetch.sv ----
// Self-checking bench for the control-block chain walker
`timescale 1ns/10ps
module tb_control_block_chain_fetch;
    import cbc_pkg::*;
    logic mclk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, doneValid = 1'b0;
    logic pready, pslverr, memReq, memWe, memAck, execGo, errorIndicator, linearMode, extEnabled;
    logic [7:0] paddr = 8'h00, wakeupJumperLow = 8'h01, wakeupJumperHigh = 8'h00;
    logic [7:0] memWdata, memRdata, execUnit, execFunction;
    logic [31:0] pwdata = 32'h0, doneCount = 32'h0, prdata, rdv;
    logic slv;
    logic [1:0] doneEvent = 2'h0;
    logic [23:0] memAddr;
    logic [15:0] execDevice;
    logic [2:0] execDeviceKind, execFuncClass;
    int errors = 0, check_count = 0;
    control_block_chain_fetch i_dut(.*);
    cbc_host_mem i_mem(.*);
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rdv = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Busy bit is masked: its value around a halt is not pinned down
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(a == REG_STATUS ? rdv & 32'hffff_ffdf : rdv, e);
    endtask
    task go(input logic [1:0] c);
        apb(1'b1, REG_CMD, {30'h0, c});
    endtask
    task ld(input logic [7:0] a, input logic [63:0] v);
        for (int i = 0; i < 8; i++) i_mem.m[a + i] = v[8 * i +: 8];
    endtask
    task run(input logic [1:0] ev, input logic [31:0] n, input logic [5:0] cls);
        while (execGo !== 1'b1) @(posedge mclk);
        chk(32'({execFuncClass, execDeviceKind}), 32'(cls));
        doneValid <= 1'b1;
        doneEvent <= ev;
        doneCount <= n;
        @(posedge mclk);
        doneValid <= 1'b0;
        while (i_mem.m[8'h43] !== SEM_POSTED) @(posedge mclk);
    endtask
    task final_report;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        final_report;
    end
    initial begin
        for (int i = 0; i < 256; i++) i_mem.m[i] = 8'h00;
        ld(8'h10, 64'h20_0005);
        ld(8'h20, 64'h44_ff01);
        ld(8'h48, 64'h80);
        ld(8'h84, 64'h0100_0001_aaaa_aaaa);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(REG_STATUS, 32'h0001_0008);
        rd(8'hfc, 32'h0);
        chk(32'(slv), 32'h1);
        go(CMD_CLEAR);
        go(CMD_START);
        while (i_mem.m[8'h21] !== BUSY_CLEAR) @(posedge mclk);
        rd(REG_STATUS, 32'h0001_0005);
        rd(REG_CCB_ADDR, 32'h20);
        rd(REG_CIB_ADDR, 32'h44);
        rd(REG_PARAMETER_BLOCK_PTR, 32'h80);
        i_mem.m[8'h10] = MODE_LIN;
        i_mem.lag = 3;
        go(CMD_START);
        run(EV_IMM, 32'h0c, {FC_XFER, KIND_FLOPPY});
        chk(i_mem.m[8'h41], 8'h09);
        chk({i_mem.m[8'h87], i_mem.m[8'h86], i_mem.m[8'h85], i_mem.m[8'h84]}, 32'h0c);
        chk(i_mem.m[8'h88], 8'h01);
        chk({execFunction, execUnit, execDevice}, 32'h0100_0001);
        i_mem.m[8'h88] = 8'h00;
        i_mem.m[8'h8b] = FN_SEEK;
        i_mem.m[8'h41] = 8'h55;
        go(CMD_START);
        fork
            run(EV_SEEK, 32'h0, {FC_SEEK, KIND_WIN});
            begin
                repeat (80) @(posedge mclk);
                chk(i_mem.m[8'h41], 8'h55);
                i_mem.m[8'h43] = SEM_FREE;
                // The semaphore was already set, so wait for the new posting here
                while (i_mem.m[8'h43] !== SEM_POSTED) @(posedge mclk);
            end
        join
        chk(i_mem.m[8'h41], 8'h09);
        rd(REG_STATUS, 32'h0001_0005);
        go(CMD_RESET);
        go(CMD_CLEAR);
        i_mem.m[8'h20] = 8'h02;
        i_mem.m[8'h21] = 8'hff;
        go(CMD_START);
        while (errorIndicator !== 1'b1) @(posedge mclk);
        rd(REG_STATUS, 32'h0800_0012);
        chk(32'({linearMode, extEnabled}), 32'h2);
        chk(i_mem.m[8'h21], 8'hff);
        final_report;
    end
endmodule
